// ---- hw/pmcc_ctrl.sv ----
`timescale 1ns/100ps
module pmcc_ctrl #(
    parameter int unsigned CYC_PER_US = pmcc_pkg::CLK_MHZ
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire pmcc_pkg::pmcc_req_t req,
    output logic [15:0]            rdata,
    input  wire logic signed [15:0] adc_shunt,
    input  wire logic [13:0]       adc_bus,
    input  wire logic              math_overflow,
    output logic                   adc_sel_bus,
    output logic                   adc_busy,
    output logic                   calibrating
);
    typedef enum logic [4:0] {
        PMCC_ST_CAL   = 5'b00001,
        PMCC_ST_IDLE  = 5'b00010,
        PMCC_ST_SHUNT = 5'b00100,
        PMCC_ST_BUS   = 5'b01000,
        PMCC_ST_OFF   = 5'b10000
    } pmcc_state_t;

    // Next values are computed per group and registered once per clock.
    logic [15:0]  ctrl_ff, nxt_ctrl;
    logic [15:0]  shunt_ff, nxt_shunt;
    logic [13:0]  bus_ff, nxt_bus;
    logic         rdy_ff, nxt_rdy;
    logic         ovf_ff, nxt_ovf;
    logic         pend_ff, nxt_pend;
    logic [31:0]  cnt_ff, nxt_cnt;
    logic [15:0]  rdata_ff, nxt_rdata;
    pmcc_state_t  st_ff, nxt_st;
    pmcc_pkg::pmcc_ctrl_t cfg;
    logic         wr_ctrl;

    assign cfg = pmcc_pkg::pmcc_ctrl_t'(ctrl_ff[14:0]);
    // A write to the control word restarts the sequencer.
    assign wr_ctrl = req.wr && (req.addr == pmcc_pkg::ADDR_CTRL);

    // Conversion length in cycles for a four-bit setting.
    function automatic logic [31:0] conv_cycles(input logic [3:0] s);
        logic [31:0] us;
        us = 32'(pmcc_pkg::BASE_US_3);
        if (!s[3]) begin
            unique case (s[1:0])
                2'd0: us = 32'(pmcc_pkg::BASE_US_0);
                2'd1: us = 32'(pmcc_pkg::BASE_US_1);
                2'd2: us = 32'(pmcc_pkg::BASE_US_2);
                2'd3: us = 32'(pmcc_pkg::BASE_US_3);
            endcase
        end else if (s[2:0] != 3'd0) begin
            us = (32'(pmcc_pkg::AVG_US_1) << (s[2:0] - 3'd1))
                 - ((32'd1 << (s[2:0] - 3'd1)) - 32'd1) * 32'd10;
        end
        conv_cycles = us * 32'(CYC_PER_US);
    endfunction

    // Sign-extends the raw reading from the width of the gain range to 16 bits.
    function automatic logic [15:0] sign_fill(input logic [15:0] v,
                                              input logic [1:0]  g);
        logic [15:0] r;
        r = v;
        unique case (g)
            2'd0: r = {{3{v[12]}}, v[12:0]};
            2'd1: r = {{2{v[13]}}, v[13:0]};
            2'd2: r = {v[14], v[14:0]};
            2'd3: r = v;
        endcase
        sign_fill = r;
    endfunction

    // Sequencer: calibration, mode decode and conversion passes.
    always_comb begin
        nxt_shunt = shunt_ff;
        nxt_bus   = bus_ff;
        nxt_rdy   = rdy_ff;
        nxt_ovf   = ovf_ff;
        nxt_pend  = pend_ff;
        nxt_cnt   = cnt_ff;
        nxt_st    = st_ff;
        if (req.rd && req.addr == pmcc_pkg::ADDR_POWER) begin
            nxt_rdy = 1'b0;
        end
        if (math_overflow) begin
            nxt_ovf = 1'b1;
        end
        unique case (st_ff)
            PMCC_ST_CAL: begin
                nxt_cnt = cnt_ff - 32'd1;
                if (cnt_ff == 32'd0) begin
                    nxt_st = PMCC_ST_IDLE;
                end
            end
            PMCC_ST_IDLE: begin
                if (cfg.mode == 3'b000 || cfg.mode == 3'b100) begin
                    nxt_st = (cfg.mode[2]) ? PMCC_ST_OFF : PMCC_ST_IDLE;
                end else if (cfg.mode[2] || pend_ff) begin
                    nxt_pend = 1'b0;
                    if (!cfg.mode[2]) begin
                        nxt_rdy = 1'b1;
                    end
                    nxt_ovf = math_overflow;
                    if (cfg.mode[0]) begin
                        nxt_st  = PMCC_ST_SHUNT;
                        nxt_cnt = conv_cycles(cfg.shunt_conv_setting);
                    end else begin
                        nxt_st  = PMCC_ST_BUS;
                        nxt_cnt = conv_cycles(cfg.bus_conv_setting);
                    end
                end
            end
            PMCC_ST_SHUNT: begin
                nxt_cnt = cnt_ff - 32'd1;
                if (cnt_ff == 32'd0) begin
                    nxt_shunt = sign_fill(adc_shunt, cfg.shunt_gain_select);
                    if (cfg.mode[1]) begin
                        nxt_st  = PMCC_ST_BUS;
                        nxt_cnt = conv_cycles(cfg.bus_conv_setting);
                    end else begin
                        nxt_st  = PMCC_ST_IDLE;
                        nxt_rdy = 1'b0;
                    end
                end
            end
            PMCC_ST_BUS: begin
                nxt_cnt = cnt_ff - 32'd1;
                if (cnt_ff == 32'd0) begin
                    nxt_bus = adc_bus;
                    nxt_st  = PMCC_ST_IDLE;
                    nxt_rdy = 1'b0;
                end
            end
            PMCC_ST_OFF: begin
                if (cfg.mode != 3'b100) begin
                    nxt_st = PMCC_ST_IDLE;
                end
            end
            default: nxt_st = PMCC_ST_IDLE;
        endcase
        if (wr_ctrl) begin
            if (req.wdata[pmcc_pkg::RST_BIT]) begin
                nxt_shunt = 16'h0000;
                nxt_bus   = 14'h0000;
                nxt_ovf   = 1'b0;
                nxt_pend  = 1'b0;
                nxt_st    = PMCC_ST_CAL;
                nxt_cnt   = 32'(pmcc_pkg::CAL_CYCLES);
            end else begin
                nxt_pend = 1'b1;
                nxt_st   = PMCC_ST_IDLE;
            end
            nxt_rdy = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shunt_ff <= 16'h0000;
            bus_ff   <= 14'h0000;
            rdy_ff   <= 1'b0;
            ovf_ff   <= 1'b0;
            pend_ff  <= 1'b0;
            cnt_ff   <= 32'(pmcc_pkg::CAL_CYCLES);
            st_ff    <= PMCC_ST_CAL;
        end else begin
            shunt_ff <= nxt_shunt;
            bus_ff   <= nxt_bus;
            rdy_ff   <= nxt_rdy;
            ovf_ff   <= nxt_ovf;
            pend_ff  <= nxt_pend;
            cnt_ff   <= nxt_cnt;
            st_ff    <= nxt_st;
        end
    end

    // Control word: soft reset restores defaults, reset bit reads back 0.
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl) begin
            if (req.wdata[pmcc_pkg::RST_BIT]) begin
                nxt_ctrl = pmcc_pkg::CTRL_RESET_VAL;
            end else begin
                nxt_ctrl = {1'b0, req.wdata[14:0]};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_ff <= pmcc_pkg::CTRL_RESET_VAL;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Read port: captures the addressed word on a read strobe.
    always_comb begin
        nxt_rdata = rdata_ff;
        if (req.rd) begin
            unique case (req.addr)
                pmcc_pkg::ADDR_CTRL:  nxt_rdata = ctrl_ff;
                pmcc_pkg::ADDR_SHUNT: nxt_rdata = shunt_ff;
                pmcc_pkg::ADDR_BUS:   nxt_rdata = {bus_ff, rdy_ff, ovf_ff};
                default:              nxt_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Status outputs decode straight from the state register.
    assign rdata       = rdata_ff;
    assign adc_sel_bus = (st_ff == PMCC_ST_BUS);
    assign adc_busy    = (st_ff == PMCC_ST_SHUNT) || (st_ff == PMCC_ST_BUS);
    assign calibrating = (st_ff == PMCC_ST_CAL);
endmodule

// ---- hw/pmcc_pkg.sv ----
// Function
// - Registers are 16-bit words at sequential addresses.
// - Writing 1 to control bit 15 resets all registers, then calibrates.
// - Bits 14:13 select bus range 16 V, 32 V, or 60 V.
// - Bits 12:11 select shunt gain 1, /2, /4, /8 with matching ranges.
// - Bits 10:7 hold the bus channel conversion setting.
// - Top bit clear picks 12 to 15-bit conversions; bit 2 ignored.
// - Top bit set picks 15-bit single or 2 to 128 sample averages.
// - Bits 2:0 pick power-down, triggered, off, or continuous modes.
// - Shunt reading holds the differential voltage with a fixed LSB weight.
// - Unused upper shunt bits are copies of the sign.
// - Shunt reading is two's complement with bit 0 weighted one.
// - In 60 V range bus value sits in bits 15:2 with flags below.
// - Bus LSB weight is the same in every bus range.
// - Ready flag is set when a triggered conversion starts, cleared when done or when the power register is read.
// - Overflow flag is set when current or power is over range.
package pmcc_pkg;
    localparam logic [3:0]  ADDR_CTRL      = 4'h0;
    localparam logic [3:0]  ADDR_SHUNT     = 4'h1;
    localparam logic [3:0]  ADDR_BUS       = 4'h2;
    localparam logic [3:0]  ADDR_POWER     = 4'h3;
    localparam logic [15:0] CTRL_RESET_VAL = 16'h799f;
    localparam int          RST_BIT        = 15;
    localparam int          RANGE_LSB      = 13;
    localparam int          GAIN_LSB       = 11;
    localparam int          BUS_CONV_LSB   = 7;
    localparam int          SH_CONV_LSB    = 3;
    localparam int          MODE_LSB       = 0;
    localparam int          CLK_MHZ        = 250;
    localparam int          CAL_CYCLES     = 16;
    localparam int          BASE_US_0      = 72;
    localparam int          BASE_US_1      = 132;
    localparam int          BASE_US_2      = 258;
    localparam int          BASE_US_3      = 508;
    localparam int          AVG_US_1       = 1010;

    typedef struct packed {
        logic [1:0] bus_range_select;
        logic [1:0] shunt_gain_select;
        logic [3:0] bus_conv_setting;
        logic [3:0] shunt_conv_setting;
        logic [2:0] mode;
    } pmcc_ctrl_t;

    typedef struct packed {
        logic [15:0] wdata;
        logic [3:0]  addr;
        logic        wr;
        logic        rd;
    } pmcc_req_t;
endpackage

// ---- test/pmcc_adc_model.sv ----
`timescale 1ns/100ps
module pmcc_adc_model (
    input  wire logic               sys_clk,
    input  wire logic               adc_busy,
    input  wire logic signed [15:0] shunt_val,
    input  wire logic [13:0]        bus_val,
    output logic signed [15:0]      adc_shunt,
    output logic [13:0]             adc_bus
);
    logic busy_q_ff;
    always_ff @(posedge sys_clk) begin
        busy_q_ff <= adc_busy;
    end
    // Results are valid only around a conversion, inverted otherwise.
    assign adc_shunt = (adc_busy | busy_q_ff) ? shunt_val : ~shunt_val;
    assign adc_bus = (adc_busy | busy_q_ff) ? bus_val : ~bus_val;
endmodule

// ---- test/pmcc_chk.sv ----
`timescale 1ns/100ps
module pmcc_chk (
    input wire logic                sys_clk,
    input wire logic                rst,
    input wire pmcc_pkg::pmcc_req_t req,
    input wire logic [15:0]         rdata,
    input wire logic                adc_sel_bus,
    input wire logic                adc_busy,
    input wire logic                calibrating
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic wc;
    assign wc = req.wr && req.addr == pmcc_pkg::ADDR_CTRL;
    a_cal_len: assert property ($fell(rst) |-> calibrating [*8] ##[1:12]
        !calibrating) else $error("calibration length wrong");
    a_cal_quiet: assert property (calibrating |-> !adc_busy)
        else $error("conversion during calibration");
    a_soft_rst: assert property (wc && req.wdata[15] |-> ##[1:2] calibrating)
        else $error("soft reset ignored");
    a_sel_busy: assert property (adc_sel_bus |-> adc_busy)
        else $error("bus select outside conversion");
    a_rdata_hold: assert property (!req.rd && !req.wr |=> $stable(rdata))
        else $error("read data moved");
    a_ctrl_back: assert property (wc && !req.wdata[15] ##1 req.rd && !req.wr
        && req.addr == pmcc_pkg::ADDR_CTRL |=> rdata ==
        {1'b0, $past(req.wdata[14:0], 2)}) else $error("bad readback");
    a_unread_zero: assert property (req.rd && req.addr >= pmcc_pkg::ADDR_POWER
        |=> rdata == 16'h0000) else $error("nonzero read");
    a_trig_start: assert property (wc && !req.wdata[15] && !calibrating &&
        req.wdata[1:0] != 2'b00 |-> ##[1:3] adc_busy)
        else $error("no pass after write");
    a_pwr_idle: assert property (wc && req.wdata[2:0] == 3'h0 && !adc_busy
        |=> !adc_busy [*8]) else $error("busy in power-down");
    cover property ($fell(calibrating));
    cover property ($rose(adc_sel_bus));
    cover property (req.rd && req.addr == pmcc_pkg::ADDR_POWER);
endmodule
bind pmcc_ctrl pmcc_chk i_pmcc_chk (.sys_clk(sys_clk), .rst(rst), .req(req),
    .rdata(rdata), .adc_sel_bus(adc_sel_bus), .adc_busy(adc_busy),
    .calibrating(calibrating));

// ---- test/pmcc_ctrl_tb.sv ----
`timescale 1ns/100ps
module pmcc_ctrl_tb;
    logic                sys_clk, rst, ovf, sel_bus, busy, cal, a, l, sb;
    pmcc_pkg::pmcc_req_t req;
    logic [15:0]         rdata, rv, t;
    logic signed [15:0]  adc_shunt, shunt_val, e;
    logic [13:0]         adc_bus, bus_val;
    int                  n_fail, samples_checked, n, tt;
`define CHK(x, y) begin samples_checked++; if ((x) !== (y)) begin \
    n_fail++; $display("ERROR t=%0t got %h exp %h", $time, x, y); end end
    pmcc_ctrl #(.CYC_PER_US(1)) i_pmcc_ctrl (.sys_clk(sys_clk), .rst(rst),
        .req(req), .rdata(rdata), .adc_shunt(adc_shunt), .adc_bus(adc_bus),
        .math_overflow(ovf), .adc_sel_bus(sel_bus), .adc_busy(busy),
        .calibrating(cal));
    pmcc_adc_model i_pmcc_adc_model (.sys_clk(sys_clk), .adc_busy(busy),
        .shunt_val(shunt_val), .bus_val(bus_val), .adc_shunt(adc_shunt),
        .adc_bus(adc_bus));
    task automatic acc(input logic [3:0] ad, input logic [15:0] d,
                       input logic w);
        @(posedge sys_clk) req <= '{d, ad, w, !w};
        @(posedge sys_clk) req <= '0;
        @(negedge sys_clk) rv = rdata;
    endtask
    task automatic idle();
        repeat (2) @(negedge sys_clk);
        for (int i = 0; i < 9000 && busy !== 1'b0; i++) @(negedge sys_clk);
    endtask
    task automatic t_regs();
        acc(4'h0, 0, 0); `CHK(rv, 16'h799f)
        acc(4'h1, 0, 0); `CHK(rv, 16'h0000)
        acc(4'hf, 0, 0); `CHK(rv, 16'h0000)
        @(posedge sys_clk) req <= '{16'h2ab0, 4'h0, 1'b1, 1'b0};
        @(posedge sys_clk) req <= '{16'h0000, 4'h0, 1'b0, 1'b1};
        @(posedge sys_clk) req <= '0;
        @(negedge sys_clk) `CHK(rdata, 16'h2ab0)
        idle();
    endtask
    task automatic t_conv();
        for (int c = 0; c < 2; c++) for (int s = 0; s < 12; s++) begin
            acc(4'h0, c ? 16'(s << 7) | 16'h2 : 16'(s << 3) | 16'h1, 1);
            tt = s < 8 ? (s % 4 == 0 ? 72 : s % 4 == 1 ? 132 : s % 4 == 2 ?
                258 : 508) : s == 8 ? 508 : 1000 * (1 << (s - 9)) + 10;
            n = 0;
            for (int i = 0; i < 9000 && !(n > 0 && busy === 1'b0); i++) begin
                @(negedge sys_clk) n += int'(busy === 1'b1);
            end
            `CHK(n >= tt && n <= tt + 3, 1'b1)
            repeat (20) @(negedge sys_clk);
            `CHK(busy, 1'b0)
        end
    endtask
    task automatic t_shunt();
        for (int g = 0; g < 4; g++) begin
            acc(4'h0, 16'(g << 11) | 16'h1, 1);
            idle();
            acc(4'h1, 0, 0);
            t = 16'h5a05 << (3 - g);
            e = $signed(t) >>> (3 - g);
            `CHK(rv, e)
        end
    endtask
    task automatic t_bus();
        for (int r = 0; r < 4; r++) begin
            acc(4'h0, 16'(r << 13) | 16'h2, 1);
            repeat (2) @(negedge sys_clk);
            acc(4'h2, 0, 0); `CHK(rv[1], 1'b1)
            acc(4'h3, 0, 0); `CHK(rv, 16'h0000)
            acc(4'h2, 0, 0); `CHK(rv[1], 1'b0)
            idle();
            acc(4'h2, 0, 0); `CHK(rv, 16'haacd)
        end
    endtask
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            acc(4'h0, 16'(m), 1);
            {a, l, sb} = 3'h0;
            for (int i = 0; i < 400; i++) begin
                @(negedge sys_clk) a |= busy;
                sb |= sel_bus;
                if (i >= 250) l |= busy;
            end
            `CHK({a, sb, l}, {m % 4 != 0, m[1] == 1, m >= 5})
            acc(4'h0, 0, 1);
            idle();
        end
    endtask
    task automatic final_report();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        #400000 n_fail++;
        final_report();
    end
    initial begin
        {n_fail, samples_checked} = 0;
        {rst, req, ovf, shunt_val, bus_val} = {1'b1, 23'h0, 16'h5a05, 14'h0};
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_conv();
        t_shunt();
        @(posedge sys_clk) {ovf, bus_val} <= {1'b1, 14'h2ab3};
        t_bus();
        t_modes();
        acc(4'h0, 16'h8000, 1);
        acc(4'h0, 0, 0); `CHK(rv, 16'h799f)
        final_report();
    end
endmodule
